// ==== qbp_pkg.sv ====
// constants and carrier types for the five-port latch and pad control block
// assumes one 40 MHz oscillator clock and a synchronous active-high reset
package qbp_pkg;

	// ----------------------------------------------------------------
	// port geometry and special-function addresses
	// ----------------------------------------------------------------
	localparam int NPORT = 5;
	localparam int PW = 8;
	localparam int P4_W = 2;
	localparam logic [7:0] ADDR_PORT0 = 8'h80;
	localparam logic [7:0] ADDR_PORT1 = 8'h90;
	localparam logic [7:0] ADDR_PORT2 = 8'ha0;
	localparam logic [7:0] ADDR_PORT3 = 8'hb0;
	localparam logic [7:0] ADDR_PORT4 = 8'hc0;
	localparam logic [2:0] IDX_PORT0 = 3'h0;
	localparam logic [2:0] IDX_PORT1 = 3'h1;
	localparam logic [2:0] IDX_PORT2 = 3'h2;
	localparam logic [2:0] IDX_PORT3 = 3'h3;
	localparam logic [2:0] IDX_PORT4 = 3'h4;
	localparam logic [7:0] LATCH_RESET = 8'hff;
	localparam logic [7:0] PORT4_MASK = 8'h03;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// strong assist pull-up timing
	// ----------------------------------------------------------------
	localparam int OSC_PERIOD_NS = 25;
	localparam int CLK_PERIOD_NS = 25;
	localparam int STRONG_PU_OSC = 2;
	localparam int STRONG_PU_NS = STRONG_PU_OSC * OSC_PERIOD_NS;
	localparam int STRONG_PU_CYC_I = (STRONG_PU_NS >= CLK_PERIOD_NS) ?
		STRONG_PU_NS / CLK_PERIOD_NS : 1;
	localparam int CNT_W = 2;
	localparam logic [CNT_W-1:0] STRONG_PU_CYC = CNT_W'(STRONG_PU_CYC_I);
	localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic bit_wr;
		logic [2:0] bit_sel;
		logic bit_val;
		logic rd_latch;
		logic rd_pin;
		logic rmw;
	} qbp_cpu_req_t;

	typedef struct packed {
		logic active;
		logic narrow_addr;
		logic [7:0] addr_data_lo;
		logic [7:0] addr_hi;
	} qbp_bus_t;

	typedef struct packed {
		logic [7:0] pin_o;
		logic [7:0] pin_oe_n;
		logic [7:0] strong_assist_pullup;
		logic [7:0] keeper_pullup;
		logic [7:0] weak_pullup;
	} qbp_pad_t;

endpackage

// ==== qbp_pad_ctl.sv ====
// pad driver control for one port: pin synchroniser, pull-up gating and
// the strong assist pull-up pulse on each zero-to-one output change
// assumes drv_val already holds the muxed output level for each line
`timescale 1ns/100ps
module qbp_pad_ctl import qbp_pkg::*; #(
	parameter int W = 8,
	parameter bit HAS_PULLUP = 1'b1,
	parameter bit BUS_ASSIST = 1'b0
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [W-1:0] drv_val,
	input wire logic bus_mode,
	input wire logic [W-1:0] analog_dis,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] pin_sync,
	output qbp_pad_t pad
);

	// ----------------------------------------------------------------
	// pin synchroniser
	// ----------------------------------------------------------------
	logic [W-1:0] pin_meta;
	logic [W-1:0] drv_prev;
	logic [CNT_W-1:0] pu_cnt [W];
	logic [W-1:0] pulse_on;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_meta <= '1;
			pin_sync <= '1;
		end else if (clk_en) begin
			pin_meta <= pin_i;
			pin_sync <= pin_meta;
		end
	end

	// ----------------------------------------------------------------
	// strong assist pulse
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			drv_prev <= '1;
			for (int i = 0; i < W; i++) begin
				pu_cnt[i] <= CNT_ZERO;
			end
		end else if (clk_en) begin
			drv_prev <= drv_val;
			for (int i = 0; i < W; i++) begin
				if (HAS_PULLUP && drv_val[i] && !drv_prev[i]) begin
					pu_cnt[i] <= STRONG_PU_CYC;
				end else if (pu_cnt[i] != CNT_ZERO) begin
					pu_cnt[i] <= pu_cnt[i] - CNT_ONE;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// pad drive and pull-up enables
	// ----------------------------------------------------------------
	always_comb begin
		pad = '0;
		pad.pin_oe_n = '1;
		for (int i = 0; i < W; i++) begin
			pulse_on[i] = (pu_cnt[i] != CNT_ZERO);
			pad.pin_o[i] = drv_val[i];
			if (HAS_PULLUP) begin
				pad.strong_assist_pullup[i] = pulse_on[i] ||
					(BUS_ASSIST && bus_mode && drv_val[i]);
				// analog lines lose the weak and keeper pull-ups, not the strong assist
				pad.weak_pullup[i] = drv_val[i] && !analog_dis[i];
				pad.keeper_pullup[i] = pin_sync[i] && drv_val[i] &&
					!analog_dis[i];
			end else begin
				// open drain outside bus cycles, input floats
				pad.strong_assist_pullup[i] = bus_mode && drv_val[i];
			end
			// a one with no assist turns the pull-down off: input state
			pad.pin_oe_n[i] = !(!drv_val[i] ||
				pad.strong_assist_pullup[i]);
		end
	end

endmodule

// ==== qbp_port_latches.sv ====
// five port latches with latch/pin read paths and pad control
// assumes the cpu presents one strobe per cycle and pulses instr_begin
// at the start of every instruction
`timescale 1ns/100ps
module qbp_port_latches import qbp_pkg::*; (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire qbp_cpu_req_t cpu_req,
	input wire logic instr_begin,
	output logic [7:0] sfr_rdata,
	output logic sfr_rvalid,
	output logic sfr_hit,
	input wire qbp_bus_t ext_bus,
	input wire logic [7:0] alt_out_port1,
	input wire logic [7:0] alt_out_port3,
	input wire logic [1:0] alt_out_port4,
	input wire logic [7:0] analog_sel_port1,
	input wire logic [NPORT-1:0][7:0] pin_i,
	output logic [NPORT-1:0][7:0] pin_sense,
	output qbp_pad_t [NPORT-1:0] pad
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [3:0] decode_port(input logic [7:0] a);
		logic [3:0] r;
		r = {1'b0, IDX_PORT0};
		unique case (a)
			ADDR_PORT0: r = {1'b1, IDX_PORT0};
			ADDR_PORT1: r = {1'b1, IDX_PORT1};
			ADDR_PORT2: r = {1'b1, IDX_PORT2};
			ADDR_PORT3: r = {1'b1, IDX_PORT3};
			ADDR_PORT4: r = {1'b1, IDX_PORT4};
			default: r = {1'b0, IDX_PORT0};
		endcase
		return r;
	endfunction

	function automatic logic [7:0] width_mask(input logic [2:0] idx);
		return (idx == IDX_PORT4) ? PORT4_MASK : LATCH_RESET;
	endfunction

	function automatic logic [7:0] merge_bit(input logic [7:0] cur,
		input logic [2:0] sel, input logic val);
		logic [7:0] r;
		r = cur;
		r[sel] = val;
		return r;
	endfunction

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic [3:0] dec;
	logic hit;
	logic [2:0] idx;

	always_comb begin
		dec = decode_port(cpu_req.addr);
		hit = dec[3];
		idx = dec[2:0];
	end

	assign sfr_hit = hit;

	// ----------------------------------------------------------------
	// port latches
	// ----------------------------------------------------------------
	logic [7:0] latch [NPORT];
	logic [7:0] next_latch;

	always_comb begin
		next_latch = latch[idx];
		if (cpu_req.bit_wr) begin
			// whole byte from the latch, one bit altered
			next_latch = merge_bit(latch[idx], cpu_req.bit_sel,
				cpu_req.bit_val);
		end else begin
			next_latch = cpu_req.wdata;
		end
		next_latch = next_latch & width_mask(idx);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			for (int p = 0; p < NPORT; p++) begin
				// port 4 keeps only its two implemented bits
				latch[p] <= LATCH_RESET & width_mask(3'(p));
			end
		end else if (clk_en) begin
			if (hit && (cpu_req.wr || cpu_req.bit_wr)) begin
				latch[idx] <= next_latch;
			end
		end
	end

	// ----------------------------------------------------------------
	// output stage registers, loaded at the next instruction start
	// ----------------------------------------------------------------
	logic [7:0] drv_q [NPORT];

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			for (int p = 0; p < NPORT; p++) begin
				drv_q[p] <= LATCH_RESET & width_mask(3'(p));
			end
		end else if (clk_en) begin
			if (instr_begin) begin
				for (int p = 0; p < NPORT; p++) begin
					drv_q[p] <= latch[p];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// read paths
	// ----------------------------------------------------------------
	logic [NPORT-1:0][7:0] sense;
	logic use_latch;

	always_comb begin
		// read-modify-write goes to the latch, plain reads to the pins
		use_latch = cpu_req.rd_latch || (cpu_req.rd_pin && cpu_req.rmw);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sfr_rdata <= ZERO_BYTE;
			sfr_rvalid <= 1'b0;
		end else if (clk_en) begin
			sfr_rvalid <= hit && (cpu_req.rd_latch || cpu_req.rd_pin);
			if (hit && use_latch) begin
				sfr_rdata <= latch[idx];
			end else if (hit && cpu_req.rd_pin) begin
				sfr_rdata <= sense[idx] & width_mask(idx);
			end
		end
	end

	assign pin_sense = sense;

	// ----------------------------------------------------------------
	// output-driver muxing
	// ----------------------------------------------------------------
	logic [NPORT-1:0][7:0] drv_val;
	logic [NPORT-1:0][7:0] analog_dis;

	always_comb begin
		drv_val = '0;
		analog_dis = '0;
		if (ext_bus.active) begin
			drv_val[IDX_PORT0] = ext_bus.addr_data_lo;
		end else begin
			drv_val[IDX_PORT0] = drv_q[IDX_PORT0];
		end
		if (ext_bus.active && !ext_bus.narrow_addr) begin
			drv_val[IDX_PORT2] = ext_bus.addr_hi;
		end else begin
			drv_val[IDX_PORT2] = drv_q[IDX_PORT2];
		end
		// the alternate output can only pull low a latch that is one
		drv_val[IDX_PORT1] = drv_q[IDX_PORT1] & alt_out_port1;
		drv_val[IDX_PORT3] = drv_q[IDX_PORT3] & alt_out_port3;
		drv_val[IDX_PORT4] = drv_q[IDX_PORT4] &
			{6'h00, alt_out_port4};
		analog_dis[IDX_PORT1] = analog_sel_port1;
	end

	// ----------------------------------------------------------------
	// pad control per port
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NPORT; g++) begin : g_pad
		localparam int GW = (g == int'(IDX_PORT4)) ? P4_W : PW;
		logic [GW-1:0] sync_w;

		qbp_pad_ctl #(
			.W(GW),
			.HAS_PULLUP(g != int'(IDX_PORT0)),
			.BUS_ASSIST(g == int'(IDX_PORT2))
		) u_pad (
			.ref_clk(ref_clk),
			.sys_rst(sys_rst),
			.clk_en(clk_en),
			.drv_val(drv_val[g][GW-1:0]),
			.bus_mode(ext_bus.active),
			.analog_dis(analog_dis[g][GW-1:0]),
			.pin_i(pin_i[g][GW-1:0]),
			.pin_sync(sync_w),
			.pad(pad[g])
		);

		if (GW < PW) begin : g_narrow
			assign sense[g] = {{(PW-GW){1'b0}}, sync_w};
		end else begin : g_full
			assign sense[g] = sync_w;
		end
	end

endmodule

// ==== qbp_port_latches_chk.sv ====
// checker for the five-port latch block, bound onto its top module
// assumes one clock domain and sync active-high reset
`timescale 1ns/100ps
module qbp_port_latches_chk import qbp_pkg::*; (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire qbp_cpu_req_t cpu_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_rvalid,
	input wire logic sfr_hit,
	input wire qbp_bus_t ext_bus,
	input wire logic [7:0] analog_sel_port1,
	input wire qbp_pad_t [NPORT-1:0] pad
);
	// ------
	// properties
	// ------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic rd_take;
	assign rd_take = clk_en & sfr_hit & (cpu_req.rd_latch | cpu_req.rd_pin);
	a_read_answer: assert property (rd_take |=> sfr_rvalid)
		else $error("read got no valid");
	a_valid_cause: assert property (sfr_rvalid |-> $past(rd_take))
		else $error("valid without read");
	a_p0_open_drain: assert property (!ext_bus.active |->
		pad[0].strong_assist_pullup == 8'h00) else $error("p0 pull-up on");
	a_p0_no_pull: assert property ((pad[0].keeper_pullup |
		pad[0].weak_pullup) == 8'h00) else $error("p0 not floating");
	a_analog_off: assert property (
		(pad[1].weak_pullup & analog_sel_port1) == 8'h00)
		else $error("analog line pulled up");
	a_weak_when_off: assert property ((pad[2].weak_pullup |
		~(pad[2].pin_oe_n | pad[2].pin_o)) == 8'hff)
		else $error("weak pull-up off");
	a_strong_two: assert property (
		clk_en && $rose(pad[1].strong_assist_pullup[0]) |=>
		pad[1].strong_assist_pullup[0] ##1 !pad[1].strong_assist_pullup[0])
		else $error("strong pulse length");
	a_bus_steer: assert property (ext_bus.active |->
		pad[0].pin_o == ext_bus.addr_data_lo) else $error("p0 not on bus");
	c_read: cover property (rd_take);
	c_strong: cover property ($rose(pad[1].strong_assist_pullup[0]));
	c_bus: cover property (ext_bus.active && ext_bus.narrow_addr);
endmodule
bind qbp_port_latches qbp_port_latches_chk i_chk (.ref_clk, .sys_rst,
	.clk_en, .cpu_req, .sfr_rdata, .sfr_rvalid, .sfr_hit, .ext_bus,
	.analog_sel_port1, .pad);

// ==== qbp_pin_model.sv ====
// pins of all five ports with their outside loads
// assumes pad controls settle before each rising edge
`timescale 1ns/100ps
module qbp_pin_model import qbp_pkg::*; (
	input wire logic ref_clk,
	input wire qbp_pad_t [NPORT-1:0] pad,
	input wire logic [NPORT-1:0][7:0] ext_low,
	output logic [NPORT-1:0][7:0] pin_i
);
	// ------
	// wire resolution
	// ------
	logic [7:0] drift = 8'h55;
	// an undriven, unpulled line wanders instead of holding a value
	always @(posedge ref_clk) drift <= ~drift;
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (!pad[p].pin_oe_n[b])
					pin_i[p][b] = pad[p].pin_o[b];
				else if (ext_low[p][b])
					pin_i[p][b] = 1'b0;
				else if (pad[p].weak_pullup[b] | pad[p].keeper_pullup[b])
					pin_i[p][b] = 1'b1;
				else
					pin_i[p][b] = drift[b];
			end
		end
	end
endmodule

// ==== tb_top.sv ====
// bench: table of latch writes and reads, then hand tests
// assumes the pin model on the pads and the bound checker
`timescale 1ns/100ps
module tb_top import qbp_pkg::*;;
	// ------
	// signals
	// ------
	typedef struct {logic [7:0] a, w, el, ep, rp;} qbp_row_t;
	qbp_row_t rows[5] = '{'{8'h80, 8'h3c, 8'h3c, 8'h00, 8'h00},
		'{8'h90, 8'h5a, 8'h5a, 8'h5a, 8'hff},
		'{8'ha0, 8'h0f, 8'h0f, 8'h0f, 8'hff},
		'{8'hb0, 8'hc3, 8'hc3, 8'hc2, 8'hfe},
		'{8'hc0, 8'hfe, 8'h02, 8'h02, 8'h03}};
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic instr_begin = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] alt_out_port1 = 8'hff;
	logic [7:0] alt_out_port3 = 8'hfe;
	logic [1:0] alt_out_port4 = 2'h3;
	qbp_cpu_req_t cpu_req = '0;
	qbp_bus_t ext_bus = '0;
	logic [7:0] analog_sel_port1 = 8'h00;
	logic [NPORT-1:0][7:0] ext_low = 40'hff;
	logic [NPORT-1:0][7:0] pin_i, pin_sense;
	logic [7:0] sfr_rdata, rd_d, n;
	logic sfr_rvalid, sfr_hit;
	qbp_pad_t [NPORT-1:0] pad;
	int n_errors = 0;
	int check_count = 0;
	always #12.5 ref_clk = ~ref_clk;
	qbp_port_latches i_dut (.ref_clk, .sys_rst, .clk_en, .cpu_req,
		.instr_begin, .sfr_rdata, .sfr_rvalid, .sfr_hit, .ext_bus,
		.alt_out_port1, .alt_out_port3, .alt_out_port4,
		.analog_sel_port1, .pin_i, .pin_sense, .pad);
	qbp_pin_model i_pins (.ref_clk, .pad, .ext_low, .pin_i);
	// ------
	// tasks
	// ------
	task automatic chk(input logic [7:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int c = 1);
		repeat (c) @(posedge ref_clk);
		#2;
	endtask
	task automatic go(input qbp_cpu_req_t r);
		tick();
		cpu_req = r;
		tick();
		cpu_req = '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic pin, rmw);
		go('{addr:a, rd_latch:!pin, rd_pin:pin, rmw:rmw, default:'0});
		chk({7'h00, sfr_rvalid}, 8'h01);
		rd_d = sfr_rdata;
	endtask
	task automatic ib();
		tick();
		instr_begin = 1'b1;
		tick();
		instr_begin = 1'b0;
	endtask
	task automatic do_rst();
		sys_rst = 1'b1;
		tick(20);
		sys_rst = 1'b0;
		foreach (rows[i]) begin
			rd(rows[i].a, 1'b0, 1'b0);
			chk(rd_d, rows[i].a == 8'hc0 ? 8'h03 : 8'hff);
			rd(rows[i].a, 1'b1, 1'b0);
			chk(rd_d, rows[i].rp);
		end
	endtask
	task automatic end_sim();
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ------
	// sequence
	// ------
	initial begin
		do_rst();
		foreach (rows[i]) begin
			go('{addr:rows[i].a, wdata:rows[i].w, wr:1'b1, default:'0});
			rd(rows[i].a, 1'b0, 1'b0);
			chk(rd_d, rows[i].el);
			rd(rows[i].a, 1'b1, 1'b1);
			chk(rd_d, rows[i].el);
			ib();
			tick(4);
			rd(rows[i].a, 1'b1, 1'b0);
			chk(rd_d, rows[i].ep);
		end
		chk(pad[1].keeper_pullup, 8'h5a);
		ext_low[1] = 8'h02;
		tick(3);
		chk(pad[1].keeper_pullup, 8'h58);
		chk(pin_sense[1], 8'h58);
		ext_low[1] = 8'h00;
		go('{addr:8'hb0, bit_wr:1'b1, bit_sel:3'h2, bit_val:1'b1, default:'0});
		go('{addr:8'hb0, bit_wr:1'b1, bit_sel:3'h7, bit_val:1'b0, default:'0});
		rd(8'hb0, 1'b0, 1'b0);
		chk(rd_d, 8'h47);
		go('{addr:8'h90, wdata:8'hff, wr:1'b1, default:'0});
		ib();
		n = 8'h00;
		repeat (6) begin
			n = n + {7'h00, pad[1].strong_assist_pullup[0]};
			tick();
		end
		chk(n, 8'h02);
		chk(pad[1].pin_oe_n, 8'hff);
		// a write while the clock enable is low must not land
		clk_en = 1'b0;
		go('{addr:8'h90, wdata:8'h00, wr:1'b1, default:'0});
		clk_en = 1'b1;
		rd(8'h90, 1'b0, 1'b0);
		chk(rd_d, 8'hff);
		alt_out_port1 = 8'h0f;
		alt_out_port4 = 2'h1;
		tick();
		chk(pad[1].pin_o, 8'h0f);
		chk(pad[4].pin_o, 8'h00);
		alt_out_port1 = 8'hff;
		alt_out_port4 = 2'h3;
		go('{addr:8'hb0, wdata:8'hff, wr:1'b1, default:'0});
		ib();
		alt_out_port3 = 8'h5a;
		tick();
		chk(pad[3].pin_o, 8'h5a);
		alt_out_port3 = 8'hfe;
		cpu_req = '{addr:8'h90, default:'0};
		tick();
		chk({7'h00, sfr_hit}, 8'h01);
		cpu_req = '{addr:8'h81, default:'0};
		tick();
		chk({7'h00, sfr_hit}, 8'h00);
		cpu_req = '0;
		go('{addr:8'h81, wdata:8'h00, wr:1'b1, default:'0});
		go('{addr:8'h81, rd_latch:1'b1, default:'0});
		chk({7'h00, sfr_rvalid}, 8'h00);
		ext_bus = '{active:1'b1, narrow_addr:1'b0, addr_data_lo:8'ha5,
			addr_hi:8'h3c};
		tick();
		chk(pad[0].pin_o, 8'ha5);
		chk(pad[2].pin_o, 8'h3c);
		chk(pad[0].strong_assist_pullup, 8'ha5);
		chk(pad[2].strong_assist_pullup & 8'h3c, 8'h3c);
		ext_bus.narrow_addr = 1'b1;
		tick();
		chk(pad[2].pin_o, 8'h0f);
		ext_bus = '0;
		analog_sel_port1 = 8'h0f;
		tick();
		chk(pad[1].weak_pullup, 8'hf0);
		analog_sel_port1 = 8'h00;
		do_rst();
		end_sim();
	end
endmodule
